// File: tcp_delay.v
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.vh"

// ===========================================================================
// delay timer: done pulses once cond has held for limit+1 cycles
module tcp_delay (
  input  wire                  clk,
  input  wire                  rst_n,
  input  wire                  cond,
  input  wire [`TCP_CNT_W-1:0] limit,
  output reg                   done
);
  reg [`TCP_CNT_W-1:0] count;

  always @(posedge clk) begin
    if (!rst_n || !cond) begin
      count <= {`TCP_CNT_W{1'b0}};
      done  <= 1'b0;
    end else if (count >= limit) begin
      count <= {`TCP_CNT_W{1'b0}};
      done  <= 1'b1; // one pulse, then restart
    end else begin
      count <= count + {{(`TCP_CNT_W-1){1'b0}}, 1'b1};
      done  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tcp_fsm.v
`timescale 1ns/1ps
`default_nettype none
`include "tcp_regs.vh"

// ===========================================================================
// two-cell protector controller
module tcp_fsm (
  input  wire SYS_CLK,
  input  wire RESETN,
  input  wire CELL_HI_OVCHG,   // a cell at or above over-charge level
  input  wire CELL_HI_REL,     // a cell at or above over-charge release
  input  wire CELL_LO_OVDIS,   // a cell at or below over-discharge level
  input  wire LOAD_NODE_LEVEL, // load node above overcurrent_level
  input  wire LOAD_ATTACHED,
  input  wire SHORT_LEVEL,     // load node at short-circuit level
  input  wire XCHG_LEVEL,      // node at or below excessive-charger level
  input  wire STBY_REL_LEVEL,  // node at or below standby release level
  input  wire ZERO_CELL,       // cell voltage zero
  input  wire ZERO_CHG_OK,     // charger difference above 0V minimum
  input  wire TEST_MODE,
  output reg  CHG_GATE,
  output reg  DIS_GATE,
  output reg  PULL_UP_EN,
  output reg  PULL_DOWN_EN,
  output reg  STANDBY
);

  // =========================================================================
  // synchronisers
  localparam NF = 11;
  wire [NF-1:0] raw = {ZERO_CHG_OK, ZERO_CELL, STBY_REL_LEVEL, XCHG_LEVEL,
                       SHORT_LEVEL, LOAD_ATTACHED, LOAD_NODE_LEVEL,
                       CELL_LO_OVDIS, CELL_HI_REL, CELL_HI_OVCHG, TEST_MODE};
  reg  [NF-1:0] meta;
  reg  [NF-1:0] sync;

  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_sync
      always @(posedge SYS_CLK) begin
        if (!RESETN) begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
        end else begin
          meta[g] <= raw[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  wire test    = sync[0];
  wire ovchg   = sync[1];
  wire hi_rel  = sync[2];
  wire ovdis   = sync[3];
  wire over_i  = sync[4];
  wire load_on = sync[5];
  wire short_l = sync[6];
  wire xchg    = sync[7];
  wire stb_rel = sync[8];
  wire zcell   = sync[9];
  wire zchg_ok = sync[10];

  // =========================================================================
  // delay limits
  // test shortens counter delays
  function [`TCP_CNT_W-1:0] lim;
    input [`TCP_CNT_W-1:0] full;
    input                  t;
    begin
      lim = t ? (full >> `TCP_TEST_SHIFT) : full;
    end
  endfunction

  // full counts are worked out as integers, then cut to the counter width
  // on purpose; the longest count still fits, so nothing is lost
  localparam integer F_OCD = `TCP_CYC_MS(`TCP_OC_DET_MS);
  localparam integer F_OCR = `TCP_CYC_MS(`TCP_OC_REL_MS);
  localparam integer F_ODD = `TCP_CYC_MS(`TCP_OD_DET_MS);
  localparam integer F_ODR = `TCP_CYC_US(`TCP_OD_REL_US);
  localparam integer F_CUD = `TCP_CYC_MS(`TCP_CUR_DET_MS);
  localparam integer F_CUR = `TCP_CYC_US(`TCP_CUR_REL_US);
  localparam integer F_SCD = `TCP_CYC_US(`TCP_SC_DET_US);
  localparam integer F_XCD = `TCP_CYC_US(`TCP_XC_DET_US);
  localparam integer F_XCR = `TCP_CYC_US(`TCP_XC_REL_US);

  localparam [`TCP_CNT_W-1:0] L_OCD = F_OCD[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_OCR = F_OCR[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_ODD = F_ODD[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_ODR = F_ODR[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_CUD = F_CUD[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_CUR = F_CUR[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_SCD = F_SCD[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_XCD = F_XCD[`TCP_CNT_W-1:0];
  localparam [`TCP_CNT_W-1:0] L_XCR = F_XCR[`TCP_CNT_W-1:0];

  // =========================================================================
  // state and qualifying conditions
  reg [`TCP_CS_W-1:0] cstate;
  reg [`TCP_DS_W-1:0] dstate;
  reg [`TCP_CS_W-1:0] next_cstate;
  reg [`TCP_DS_W-1:0] next_dstate;
  reg                 next_standby;
  reg                 in_short;

  wire in_ovchg = (cstate == `TCP_CS_OVCHG);

  // release when node low, or high with load attached
  // any cell above release keeps gate low
  wire rel_ok = !hi_rel && (!over_i || load_on);

  // excessive charger only while discharge gate high
  wire xc_cond = xchg && (dstate == `TCP_DS_NORM)
                 && (cstate == `TCP_CS_NORM);

  wire cur_cond = over_i && !in_ovchg && (dstate == `TCP_DS_NORM);

  // over-discharge waits for over-charge to clear
  wire od_cond = ovdis && !in_ovchg && (dstate != `TCP_DS_OVDIS)
                 && !STANDBY;

  // timer pulses, one per delay
  wire d_ocd;
  wire d_ocr;
  wire d_odd;
  wire d_odr;
  wire d_cud;
  wire d_cur;
  wire d_scd;
  wire d_xcd;
  wire d_xcr;

  // =========================================================================
  // timer qualifiers; a counter restarts as soon as its qualifier drops
  // kept as named nets so each timer below is one plain hookup
  wire c_ocd = ovchg && !in_ovchg;
  wire c_ocr = in_ovchg && rel_ok;
  wire c_odr = (dstate == `TCP_DS_OVDIS) && !STANDBY && !ovdis;
  wire c_cur = (dstate == `TCP_DS_CUR) && !over_i && !in_short;
  wire c_scd = short_l && !in_short;
  wire c_xcr = (cstate == `TCP_CS_XCHG) && !xchg;

  // =========================================================================
  // limits in use; the test flag is synchronised like every other flag
  // one shift for every counter but the short-circuit one keeps the test path small
  wire [`TCP_CNT_W-1:0] m_ocd = lim(L_OCD, test);
  wire [`TCP_CNT_W-1:0] m_ocr = lim(L_OCR, test);
  wire [`TCP_CNT_W-1:0] m_odd = lim(L_ODD, test);
  wire [`TCP_CNT_W-1:0] m_odr = lim(L_ODR, test);
  wire [`TCP_CNT_W-1:0] m_cud = lim(L_CUD, test);
  wire [`TCP_CNT_W-1:0] m_cur = lim(L_CUR, test);
  wire [`TCP_CNT_W-1:0] m_xcd = lim(L_XCD, test);
  wire [`TCP_CNT_W-1:0] m_xcr = lim(L_XCR, test);

  // =========================================================================
  // delay timers
  // over-charge detection timer
  tcp_delay u_ocd (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (c_ocd),
    .limit (m_ocd),
    .done  (d_ocd)
  );

  tcp_delay u_ocr (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (c_ocr),
    .limit (m_ocr),
    .done  (d_ocr)
  );

  tcp_delay u_odd (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (od_cond),
    .limit (m_odd),
    .done  (d_odd)
  );

  tcp_delay u_odr (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (c_odr),
    .limit (m_odr),
    .done  (d_odr)
  );

  tcp_delay u_cud (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (cur_cond),
    .limit (m_cud),
    .done  (d_cud)
  );

  tcp_delay u_cur (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (c_cur),
    .limit (m_cur),
    .done  (d_cur)
  );

  // short delay is fixed, not shortened
  // short detection independent of other states except over-discharge, where its pulse is ignored
  tcp_delay u_scd (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (c_scd),
    .limit (L_SCD),
    .done  (d_scd)
  );

  tcp_delay u_xcd (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (xc_cond),
    .limit (m_xcd),
    .done  (d_xcd)
  );

  tcp_delay u_xcr (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cond  (c_xcr),
    .limit (m_xcr),
    .done  (d_xcr)
  );

  // =========================================================================
  // charge-side next state
  always @* begin
    next_cstate = cstate;
    case (cstate)
      `TCP_CS_NORM: begin
        if (d_ocd)
          next_cstate = `TCP_CS_OVCHG;
        else if (d_xcd)
          next_cstate = `TCP_CS_XCHG;
      end
      `TCP_CS_OVCHG: begin
        // excessive-charger check only after this release
        if (d_ocr)
          next_cstate = `TCP_CS_NORM;
      end
      `TCP_CS_XCHG: begin
        if (d_ocd)
          next_cstate = `TCP_CS_OVCHG;
        else if (d_xcr)
          next_cstate = `TCP_CS_NORM;
      end
      default: next_cstate = `TCP_CS_NORM;
    endcase
  end

  // =========================================================================
  // discharge-side next state
  always @* begin
    next_dstate  = dstate;
    next_standby = STANDBY;
    case (dstate)
      `TCP_DS_NORM: begin
        if (d_odd) begin
          next_dstate  = `TCP_DS_OVDIS;
          next_standby = 1'b1;
        end else if (d_cud || d_scd)
          next_dstate = `TCP_DS_CUR;
      end
      `TCP_DS_OVDIS: begin
        if (STANDBY && stb_rel)
          next_standby = 1'b0;
        if (d_odr)
          next_dstate = `TCP_DS_NORM;
      end
      `TCP_DS_CUR: begin
        // over-discharge during current fault moves to standby
        if (d_odd) begin
          next_dstate  = `TCP_DS_OVDIS;
          next_standby = 1'b1;
        end else if (d_cur)
          next_dstate = `TCP_DS_NORM;
      end
      default: next_dstate = `TCP_DS_NORM;
    endcase
  end

  // =========================================================================
  // state registers
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      cstate   <= `TCP_CS_NORM;
      dstate   <= `TCP_DS_NORM;
      STANDBY  <= 1'b0;
      in_short <= 1'b0;
    end else begin
      cstate  <= next_cstate;
      dstate  <= next_dstate;
      STANDBY <= next_standby;
      // short latch holds until node falls below over-current level
      if (d_scd && dstate != `TCP_DS_OVDIS)
        in_short <= 1'b1;
      else if (!over_i && !short_l)
        in_short <= 1'b0;
    end
  end

  // =========================================================================
  // registered outputs
  always @(posedge SYS_CLK) begin
    if (!RESETN) begin
      CHG_GATE     <= 1'b1;
      DIS_GATE     <= 1'b1;
      PULL_UP_EN   <= 1'b0;
      PULL_DOWN_EN <= 1'b0;
    end else begin
      // zero-volt cell: charge gate follows zchg_ok, high only with enough charger voltage
      if (zcell)
        CHG_GATE <= zchg_ok;
      else
        CHG_GATE <= (next_cstate == `TCP_CS_NORM);
      DIS_GATE     <= (next_dstate == `TCP_DS_NORM);
      PULL_UP_EN   <= (next_dstate == `TCP_DS_OVDIS);
      PULL_DOWN_EN <= (next_dstate == `TCP_DS_CUR);
    end
  end

endmodule
`default_nettype wire

// File: tcp_fsm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// port-level checker for the protector controller
module tcp_fsm_chk (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CELL_HI_OVCHG,
  input wire logic CELL_LO_OVDIS,
  input wire logic LOAD_NODE_LEVEL,
  input wire logic SHORT_LEVEL,
  input wire logic XCHG_LEVEL,
  input wire logic STBY_REL_LEVEL,
  input wire logic ZERO_CELL,
  input wire logic ZERO_CHG_OK,
  input wire logic CHG_GATE,
  input wire logic DIS_GATE,
  input wire logic PULL_UP_EN,
  input wire logic PULL_DOWN_EN,
  input wire logic STANDBY
);
  wire       flt = CELL_LO_OVDIS | LOAD_NODE_LEVEL | SHORT_LEVEL;
  wire       chg = CELL_HI_OVCHG | XCHG_LEVEL;
  logic [7:0] flt_cnt, ok_cnt, chg_cnt, sr_cnt;
  // run lengths of raw conditions; saturate at 255 so long runs do not wrap
  always @(posedge SYS_CLK) begin
    flt_cnt <= !flt ? 8'h00 : flt_cnt + {7'h0, flt_cnt != 8'hff};
    ok_cnt  <= flt ? 8'h00 : ok_cnt + {7'h0, ok_cnt != 8'hff};
    chg_cnt <= !chg ? 8'h00 : chg_cnt + {7'h0, chg_cnt != 8'hff};
    sr_cnt  <= !STBY_REL_LEVEL ? 8'h00 : sr_cnt + {7'h0, sr_cnt != 8'hff};
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  property p_dis_fall; $fell(DIS_GATE) |-> flt_cnt >= 8'd100; endproperty
  a_dis_fall: assert property (p_dis_fall)
    else $error("discharge gate fell on a brief condition");
  property p_dis_rise; $rose(DIS_GATE) |-> ok_cnt >= 8'd100; endproperty
  a_dis_rise: assert property (p_dis_rise)
    else $error("discharge gate rose before release delay");
  property p_chg_fall;
    $fell(CHG_GATE) && !ZERO_CELL |-> chg_cnt >= 8'd100;
  endproperty
  a_chg_fall: assert property (p_chg_fall)
    else $error("charge gate fell without a held cause");
  property p_stby_up; STANDBY |-> PULL_UP_EN && !PULL_DOWN_EN; endproperty
  a_stby_up: assert property (p_stby_up)
    else $error("standby without pull-up only");
  property p_stby_rise;
    $rose(STANDBY) |-> !DIS_GATE && $past(CELL_LO_OVDIS, 3);
  endproperty
  a_stby_rise: assert property (p_stby_rise)
    else $error("standby entered without over-discharge");
  property p_pd; $rose(PULL_DOWN_EN) |-> !DIS_GATE && !STANDBY; endproperty
  a_pd: assert property (p_pd)
    else $error("pull-down on with discharge gate high");
  property p_stby_fall; $fell(STANDBY) |-> sr_cnt >= 8'd2; endproperty
  a_stby_fall: assert property (p_stby_fall)
    else $error("standby left without release level");
  property p_zero; (ZERO_CELL && ZERO_CHG_OK)[*5] |-> CHG_GATE; endproperty
  a_zero: assert property (p_zero)
    else $error("zero-volt cell charging not enabled");
endmodule

bind tcp_fsm tcp_fsm_chk u_chk (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .CELL_HI_OVCHG(CELL_HI_OVCHG),
  .CELL_LO_OVDIS(CELL_LO_OVDIS), .LOAD_NODE_LEVEL(LOAD_NODE_LEVEL),
  .SHORT_LEVEL(SHORT_LEVEL), .XCHG_LEVEL(XCHG_LEVEL),
  .STBY_REL_LEVEL(STBY_REL_LEVEL), .ZERO_CELL(ZERO_CELL),
  .ZERO_CHG_OK(ZERO_CHG_OK), .CHG_GATE(CHG_GATE), .DIS_GATE(DIS_GATE),
  .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .STANDBY(STANDBY)
);
`default_nettype wire

// File: tcp_fsm_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// directed bench, shortened delays except the short-circuit one
module tcp_fsm_tb;
  logic clk = 0, rstn = 0, ovchg = 0, hirel = 0, lodis = 0, ld_on = 0;
  logic heavy = 0, shrt = 0, chg = 0, xs = 0, zc = 0, tm = 1;
  wire  ll, sl, xl, sr, zo, cg, dg, pu, pd, sb;
  wire  [4:0] obs = {sb, pd, pu, dg, cg};
  int   n_mismatch = 0, n_tests = 0;
  always #4 clk = ~clk;
  tcp_pack_model pm (.dis_gate(dg), .heavy(heavy), .short_ld(shrt),
    .load_on(ld_on), .charger(chg), .xs_chg(xs), .load_lvl(ll),
    .short_lvl(sl), .xchg_lvl(xl), .stby_rel(sr), .zero_ok(zo));
  tcp_fsm dut (.SYS_CLK(clk), .RESETN(rstn), .CELL_HI_OVCHG(ovchg),
    .CELL_HI_REL(hirel), .CELL_LO_OVDIS(lodis), .LOAD_NODE_LEVEL(ll),
    .LOAD_ATTACHED(ld_on), .SHORT_LEVEL(sl), .XCHG_LEVEL(xl),
    .STBY_REL_LEVEL(sr), .ZERO_CELL(zc), .ZERO_CHG_OK(zo),
    .TEST_MODE(tm), .CHG_GATE(cg), .DIS_GATE(dg), .PULL_UP_EN(pu),
    .PULL_DOWN_EN(pd), .STANDBY(sb));
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %b got %b", nm, e, g);
    end
  endtask
  // count falling edges until output i shows v; window in cycles
  task automatic wait_o(input int i, input logic v, input int lo,
                        input int hi, input string nm);
    int n;
    n = 0;
    while (obs[i] !== v && n <= hi) begin
      @(negedge clk);
      n++;
    end
    n_tests++;
    if (n < lo || n > hi) begin
      n_mismatch++;
      $display("FAIL %s exp %0d..%0d got %0d", nm, lo, hi, n);
    end
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    chk("reset outputs", 1'b1, obs === 5'h03);
  endtask
  // normal mode: short fires long before the over-current count
  task automatic t_short;
    tm = 0; ld_on = 1; heavy = 1; shrt = 1;
    wait_o(1, 1'b0, 31250, 31255, "short det");
    chk("short pulldown", 1'b1, pd);
    chk("short standby", 1'b0, sb);
    tm = 1; ld_on = 0; heavy = 0; shrt = 0;
    wait_o(1, 1'b1, 122, 127, "short rel");
  endtask
  // broken heavy load must not trip: count restarts
  task automatic t_glitch;
    heavy = 1;
    repeat (2000) @(negedge clk);
    heavy = 0;
    repeat (5) @(negedge clk);
    heavy = 1;
    repeat (2000) @(negedge clk);
    heavy = 0;
    // let the timer see the drop before the next task raises heavy
    repeat (10) @(negedge clk);
    chk("glitch gate", 1'b1, dg);
  endtask
  task automatic t_cur;
    ld_on = 1; heavy = 1;
    wait_o(1, 1'b0, 2441, 2446, "cur det");
    chk("cur pulldown", 1'b1, pd);
    chk("cur standby", 1'b0, sb);
    // excessive charger must be ignored while the discharge gate is low
    xs = 1;
    repeat (300) @(negedge clk);
    chk("xchg blocked", 1'b1, cg);
    xs = 0;
    ld_on = 0; heavy = 0;
    wait_o(1, 1'b1, 122, 127, "cur rel");
  endtask
  task automatic t_xchg;
    xs = 1;
    repeat (100) @(negedge clk);
    xs = 0;
    repeat (300) @(negedge clk);
    chk("xchg abort", 1'b1, cg);
    xs = 1;
    wait_o(0, 1'b0, 183, 188, "xchg det");
    xs = 0;
    wait_o(0, 1'b1, 183, 188, "xchg rel");
  endtask
  task automatic t_odis;
    lodis = 1;
    wait_o(1, 1'b0, 12207, 12212, "odis det");
    chk("odis pullup", 1'b1, pu);
    chk("odis standby", 1'b1, sb);
    lodis = 0;
    repeat (300) @(negedge clk);
    chk("standby held", 1'b1, sb);
    chg = 1;
    wait_o(4, 1'b0, 2, 5, "standby exit");
    wait_o(1, 1'b1, 120, 127, "odis rel");
    chg = 0;
  endtask
  task automatic t_zero;
    zc = 1;
    wait_o(0, 1'b0, 1, 6, "zero no chg");
    chg = 1;
    wait_o(0, 1'b1, 1, 6, "zero chg");
    zc = 0; chg = 0;
    repeat (10) @(negedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rstn = 1;
    repeat (3) @(negedge clk);
    t_reset;
    t_short;
    t_glitch;
    t_cur;
    t_xchg;
    t_odis;
    t_zero;
    report_and_stop;
  end
  // watchdog: about 52k cycles of work expected
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// File: tcp_pack_model.sv
`timescale 1ns/1ps
`default_nettype none
// ===========================================================
// load, charger and fet network seen at the load node
module tcp_pack_model (
  input  wire logic dis_gate,
  input  wire logic heavy,
  input  wire logic short_ld,
  input  wire logic load_on,
  input  wire logic charger,
  input  wire logic xs_chg,
  output wire logic load_lvl,
  output wire logic short_lvl,
  output wire logic xchg_lvl,
  output wire logic stby_rel,
  output wire logic zero_ok
);
  // open fet: an attached load drags the node up until removed
  assign load_lvl  = dis_gate ? (heavy | short_ld) : load_on;
  assign short_lvl = short_ld & (dis_gate | load_on);
  // charger pulls the node low whatever the gate state
  assign xchg_lvl  = xs_chg;
  assign stby_rel  = charger | xs_chg;
  assign zero_ok   = charger;
endmodule
`default_nettype wire

// File: tcp_regs.vh
// Contract
// - either cell over-charge: charge gate low after over-charge delay.
// - over-current detection suppressed while in over-charge state.
// - short-circuit detection stays active during over-charge state.
// - both cells below release level: charge gate high after release delay.
// - node high, load on, a cell above release: charge gate stays low.
// - excessive-charger check starts only after over-charge release.
// - either cell over-discharge: discharge gate low after detection delay.
// - after over-discharge: standby, pull-up to positive supply on.
// - leave standby only when a charger pulls node to release level.
// - both cells above over-discharge: discharge gate high after delay.
// - load node over-current: discharge gate low after delay, pull-down on.
// - over-current detection never causes standby.
// - short circuit: discharge gate low after shorter delay, pull-down on.
// - short-circuit detection never causes standby.
// - node back below over-current level: discharge gate high after delay.
// - excessive charger: charge gate low after internal detection delay.
// - excessive charger clearing early abandons detection, gate unchanged.
// - excessive charger gone: charge gate high after internal release delay.
// - no excessive-charger detection while discharge gate low.
// - zero-volt cell with enough charger voltage: charge gate high.
// - test pin high shortens counter delays; short-circuit delay unaffected.
// - over-charge beats over-discharge; over-discharge resumes after.
// - short-circuit detection runs independently of all other states. (code: a detection during over-discharge is ignored.)
`ifndef TCP_REGS_VH
`define TCP_REGS_VH

// ===========================================================================
// timing figures as printed, in their own units
`define TCP_CLK_HZ        125000000
`define TCP_OC_DET_MS     1000
`define TCP_OC_REL_MS     40
`define TCP_OD_DET_MS     100
`define TCP_OD_REL_US     1000
`define TCP_CUR_DET_MS    20
`define TCP_CUR_REL_US    1000
`define TCP_SC_DET_US     250
`define TCP_XC_DET_US     1500
`define TCP_XC_REL_US     1500

// ===========================================================================
// derived cycle counts (typical figures, 125 MHz)
`define TCP_CYC_MS(x)     ((x) * (`TCP_CLK_HZ / 1000))
`define TCP_CYC_US(x)     ((x) * (`TCP_CLK_HZ / 1000000))
`define TCP_CNT_W         28
// test mode divides counter delays by this shift
`define TCP_TEST_SHIFT    10

// ===========================================================================
// charge-side states
`define TCP_CS_W          2
`define TCP_CS_NORM       2'h0
`define TCP_CS_OVCHG      2'h1
`define TCP_CS_XCHG       2'h2
// discharge-side states
`define TCP_DS_W          2
`define TCP_DS_NORM       2'h0
`define TCP_DS_OVDIS      2'h1
`define TCP_DS_CUR        2'h2

`endif
